// [rtl/tpo_pkg.sv]
// package: constants, state and register layout of the pwm2 one-shot timer
package tpo_pkg;
    // ************
    // register map
    // ************
    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_CFG  = 5'h04;
    localparam logic [4:0] OFS_PER  = 5'h08;
    localparam logic [4:0] OFS_END  = 5'h0C;
    localparam logic [4:0] OFS_WAIT = 5'h10;
    localparam logic [4:0] OFS_CNT  = 5'h14;
    localparam logic [4:0] OFS_STAT = 5'h18;
    // ************
    // fields
    // ************
    localparam int B_RUN  = 0;
    localparam int B_LVL  = 0;
    localparam int B_CLEAR_SELECT_BIT = 1;
    localparam int B_SRC  = 2;
    localparam int B_EDG  = 5;
    localparam int B_SOM  = 7;
    localparam int F_PER  = 0;
    localparam int F_END  = 1;
    localparam int F_WAIT = 2;
    localparam int F_OVF  = 3;
    localparam int B_RUNS = 4;
    localparam int B_TRG  = 5;
    localparam int B_OUT  = 6;
    // ************
    // codes and reset values
    // ************
    localparam logic [2:0]  SRC_D1  = 3'h0;
    localparam logic [2:0]  SRC_D2  = 3'h1;
    localparam logic [2:0]  SRC_D4  = 3'h2;
    localparam logic [2:0]  SRC_D8  = 3'h3;
    localparam logic [2:0]  SRC_D32 = 3'h4;
    localparam logic [2:0]  SRC_OSC = 3'h5;
    localparam logic [2:0]  SRC_EXT = 3'h6;
    localparam logic [1:0]  EDG_OFF  = 2'h0;
    localparam logic [1:0]  EDG_RISE = 2'h1;
    localparam logic [1:0]  EDG_FALL = 2'h2;
    localparam logic [15:0] CNT_MAX  = 16'hFFFF;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [1:0]  RSP_OK  = 2'h0;
    localparam logic [1:0]  RSP_ERR = 2'h2;

    typedef enum logic [2:0] {
        TPO_IDLE = 3'b001,
        TPO_ARM  = 3'b010,
        TPO_RUN  = 3'b100
    } tpo_fsm_e;

    typedef struct packed {
        tpo_fsm_e    fsm;
        logic        run;
        logic        lvl;
        logic        clear_select_bit;
        logic [2:0]  src;
        logic [1:0]  edg;
        logic        som;
        logic [15:0] per;
        logic [15:0] endv;
        logic [15:0] wtv;
        logic [15:0] cnt;
        logic [3:0]  flg;
        logic [4:0]  pre;
        logic [2:0]  csy;
        logic [2:0]  osy;
        logic [2:0]  tsy;
        logic        wout;
        logic        evt;
        logic        awr;
        logic        wr;
        logic        bv;
        logic [1:0]  bresp;
        logic        awh;
        logic [4:0]  awa;
        logic        wh;
        logic [31:0] wd;
        logic [3:0]  ws;
        logic        arr;
        logic        rv;
        logic [1:0]  rresp;
        logic [31:0] rd;
    } tpo_st_s;
endpackage

// [rtl/tpo_timer.sv]
// pwm2 one-shot timer: 16-bit counter, waveform pin, axi4-lite register slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/1ps
// Function
// - count source: dividers, fast osc, external clock
// - free period lasts m plus one ticks
// - active width is n minus p ticks
// - output active p plus one ticks after start
// - active after wait, inactive later, one-shot halts
// - no trigger or no stop: run bit starts
// - trigger and stop-on-match enabled, run: edge starts count
// - run bit zero stops, initial level, count kept
// - stop-on-match: period match stops, initial level
// - period stop keeps or clears counter per bit
// - without stop-on-match counter runs continuously
// - event on any compare match and overflow
// - trigger pin port or trigger, wave pin output
// - level select bit sets output polarity
// - trigger edge rising, falling or both
module tpo_timer #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // axi4-lite write
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // axi4-lite read
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // pins and clocks from outside
    input  wire logic              ext_count_clock_pin,
    input  wire logic              fast_internal_osc_clk,
    input  wire logic              ext_trigger_pin,
    // waveform and event
    output logic                   wave_out_pin,
    output logic                   event_pulse
);
    // ************
    // checks and state
    // ************
    if (ADDR_W < 6) begin : g_addr_chk // decode needs bits 4:0 and an upper bit
        $error("tpo_timer: ADDR_W below 6");
    end

    tpo_pkg::tpo_st_s st;
    tpo_pkg::tpo_st_s nx;
    logic             tick;
    logic             trg_edge;
    logic             hit_per;
    logic             hit_end;
    logic             hit_wait;
    logic             do_wr;
    logic             ctrl_wr;
    logic             start_wr;
    logic [31:0]      wmask;
    logic [31:0]      wval;
    logic [31:0]      rval;
    logic             rhit;
    logic [3:0]       fset;

    // byte lanes of the pending write become a bit mask
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_strb
            assign wmask[8*gi +: 8] = {8{st.ws[gi]}};
        end
    endgenerate

    // ************
    // count source and trigger decode
    // ************
    // only the second and third sync stages are looked at
    always_comb begin
        case (st.src)
            tpo_pkg::SRC_D1:  tick = 1'b1;
            tpo_pkg::SRC_D2:  tick = &st.pre[0];
            tpo_pkg::SRC_D4:  tick = &st.pre[1:0];
            tpo_pkg::SRC_D8:  tick = &st.pre[2:0];
            tpo_pkg::SRC_D32: tick = &st.pre;
            tpo_pkg::SRC_OSC: tick = st.osy[1] & ~st.osy[2];
            tpo_pkg::SRC_EXT: tick = st.csy[1] & ~st.csy[2];
            default:          tick = 1'b0;
        endcase
        case (st.edg)
            tpo_pkg::EDG_OFF:  trg_edge = 1'b0;
            tpo_pkg::EDG_RISE: trg_edge = st.tsy[1] & ~st.tsy[2];
            tpo_pkg::EDG_FALL: trg_edge = ~st.tsy[1] & st.tsy[2];
            default:           trg_edge = st.tsy[1] ^ st.tsy[2];
        endcase
    end

    // compares against the counter
    assign hit_per  = st.cnt == st.per;
    assign hit_end  = st.cnt == st.endv;
    assign hit_wait = st.cnt == st.wtv;

    // write strobes of the register file
    assign do_wr    = st.awh & st.wh & ~st.bv;
    assign wval     = st.wd & wmask;
    assign ctrl_wr  = do_wr && st.awa == tpo_pkg::OFS_CTRL && st.ws[0];
    assign start_wr = ctrl_wr && st.wd[tpo_pkg::B_RUN] && st.fsm == tpo_pkg::TPO_IDLE;

    // ************
    // read mux
    // ************
    always_comb begin
        rval = 32'h0000_0000;
        rhit = 1'b1;
        case (s_axi_araddr[4:0])
            tpo_pkg::OFS_CTRL: rval[tpo_pkg::B_RUN] = st.run;
            tpo_pkg::OFS_CFG: begin
                rval[tpo_pkg::B_LVL]        = st.lvl;
                rval[tpo_pkg::B_CLEAR_SELECT_BIT]       = st.clear_select_bit;
                rval[tpo_pkg::B_SRC +: 3]   = st.src;
                rval[tpo_pkg::B_EDG +: 2]   = st.edg;
                rval[tpo_pkg::B_SOM]        = st.som;
            end
            tpo_pkg::OFS_PER:  rval[15:0] = st.per;
            tpo_pkg::OFS_END:  rval[15:0] = st.endv;
            tpo_pkg::OFS_WAIT: rval[15:0] = st.wtv;
            tpo_pkg::OFS_CNT:  rval[15:0] = st.cnt;
            tpo_pkg::OFS_STAT: begin
                rval[3:0]                = st.flg;
                rval[tpo_pkg::B_RUNS]    = st.fsm == tpo_pkg::TPO_RUN;
                rval[tpo_pkg::B_TRG]     = st.tsy[1];
                rval[tpo_pkg::B_OUT]     = st.wout;
            end
            default: rhit = 1'b0;
        endcase
        if (s_axi_araddr[ADDR_W-1:5] != '0) begin
            rhit = 1'b0;
        end
    end

    // ************
    // next state
    // ************
    always_comb begin
        nx   = st;
        fset = 4'h0;
        // synchronisers and prescaler
        nx.csy = {st.csy[1:0], ext_count_clock_pin};
        nx.osy = {st.osy[1:0], fast_internal_osc_clk};
        nx.tsy = {st.tsy[1:0], ext_trigger_pin};
        nx.pre = st.pre + 5'h01;
        nx.evt = 1'b0;

        // counting engine
        case (st.fsm)
            tpo_pkg::TPO_IDLE: begin
                nx.wout = st.lvl;
            end
            tpo_pkg::TPO_ARM: begin
                nx.wout = st.lvl;
                if (trg_edge) begin
                    nx.fsm = tpo_pkg::TPO_RUN;
                end
            end
            tpo_pkg::TPO_RUN: begin
                if (tick) begin
                    fset[tpo_pkg::F_PER]  = hit_per;
                    fset[tpo_pkg::F_END]  = hit_end;
                    fset[tpo_pkg::F_WAIT] = hit_wait;
                    if (hit_wait) begin
                        nx.wout = ~st.lvl;
                    end
                    if (hit_end) begin
                        nx.wout = st.lvl;
                    end
                    if (hit_per && st.som) begin
                        // one-shot: halt, then re-arm if a trigger is in use
                        nx.wout = st.lvl;
                        nx.cnt  = st.clear_select_bit ? tpo_pkg::CNT_ZERO : st.cnt;
                        if (st.edg == tpo_pkg::EDG_OFF) begin
                            nx.fsm = tpo_pkg::TPO_IDLE;
                            nx.run = 1'b0;
                        end else begin
                            nx.fsm = tpo_pkg::TPO_ARM;
                        end
                    end else if (hit_per) begin
                        nx.cnt  = tpo_pkg::CNT_ZERO;
                        nx.wout = st.lvl;
                    end else begin
                        fset[tpo_pkg::F_OVF] = st.cnt == tpo_pkg::CNT_MAX;
                        nx.cnt = st.cnt + 16'h0001;
                    end
                end
            end
            default: nx.fsm = tpo_pkg::TPO_IDLE;
        endcase
        nx.evt = |fset;

        // axi write channels, taken in either order
        if (s_axi_awvalid && st.awr) begin
            nx.awh = 1'b1;
            nx.awa = s_axi_awaddr[4:0];
            nx.awr = 1'b0;
        end
        if (s_axi_wvalid && st.wr) begin
            nx.wh = 1'b1;
            nx.wd = s_axi_wdata;
            nx.ws = s_axi_wstrb;
            nx.wr = 1'b0;
        end
        if (do_wr) begin
            nx.awh   = 1'b0;
            nx.wh    = 1'b0;
            nx.bv    = 1'b1;
            nx.bresp = tpo_pkg::RSP_OK;
            case (st.awa)
                tpo_pkg::OFS_CTRL: begin
                    if (ctrl_wr) begin
                        nx.run = st.wd[tpo_pkg::B_RUN];
                        if (!st.wd[tpo_pkg::B_RUN]) begin
                            nx.fsm  = tpo_pkg::TPO_IDLE;
                            nx.wout = st.lvl;
                            nx.cnt  = st.cnt;
                        end else if (start_wr) begin
                            // trigger gates the start only in one-shot use
                            if (st.edg == tpo_pkg::EDG_OFF || !st.som) begin
                                nx.fsm = tpo_pkg::TPO_RUN;
                            end else begin
                                nx.fsm = tpo_pkg::TPO_ARM;
                            end
                        end
                    end
                end
                tpo_pkg::OFS_CFG: begin
                    if (st.ws[0]) begin
                        nx.lvl  = st.wd[tpo_pkg::B_LVL];
                        nx.clear_select_bit = st.wd[tpo_pkg::B_CLEAR_SELECT_BIT];
                        nx.src  = st.wd[tpo_pkg::B_SRC +: 3];
                        nx.edg  = st.wd[tpo_pkg::B_EDG +: 2];
                        nx.som  = st.wd[tpo_pkg::B_SOM];
                    end
                end
                tpo_pkg::OFS_PER:  nx.per  = (st.per & ~wmask[15:0]) | wval[15:0];
                tpo_pkg::OFS_END:  nx.endv = (st.endv & ~wmask[15:0]) | wval[15:0];
                tpo_pkg::OFS_WAIT: nx.wtv  = (st.wtv & ~wmask[15:0]) | wval[15:0];
                tpo_pkg::OFS_CNT:  nx.cnt  = (st.cnt & ~wmask[15:0]) | wval[15:0];
                tpo_pkg::OFS_STAT: nx.flg  = st.flg & ~wval[3:0];
                default:           nx.bresp = tpo_pkg::RSP_ERR;
            endcase
        end
        // a new event beats a clear in the same cycle
        nx.flg = nx.flg | fset;
        if (st.bv && s_axi_bready) begin
            nx.bv  = 1'b0;
            nx.awr = 1'b1;
            nx.wr  = 1'b1;
        end

        // axi read channel, one outstanding read
        if (s_axi_arvalid && st.arr) begin
            nx.arr   = 1'b0;
            nx.rv    = 1'b1;
            nx.rd    = rval;
            nx.rresp = rhit ? tpo_pkg::RSP_OK : tpo_pkg::RSP_ERR;
        end
        if (st.rv && s_axi_rready) begin
            nx.rv  = 1'b0;
            nx.arr = 1'b1;
        end
    end

    // ************
    // state register
    // ************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st     <= '0;
            st.fsm <= tpo_pkg::TPO_IDLE;
            st.awr <= 1'b1;
            st.wr  <= 1'b1;
            st.arr <= 1'b1;
        end else begin
            st <= nx;
        end
    end

    // outputs straight from the state flops
    assign s_axi_awready = st.awr;
    assign s_axi_wready  = st.wr;
    assign s_axi_bvalid  = st.bv;
    assign s_axi_bresp   = st.bresp;
    assign s_axi_arready = st.arr;
    assign s_axi_rvalid  = st.rv;
    assign s_axi_rdata   = st.rd;
    assign s_axi_rresp   = st.rresp;
    assign wave_out_pin  = st.wout;
    assign event_pulse   = st.evt;

    // ************
    // assertions
    // ************
    logic run_tk;
    assign run_tk = st.fsm == tpo_pkg::TPO_RUN && tick && !do_wr;
    // every check runs on aclk and sleeps through reset
    default clocking cb_asrt @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_bwait;
        st.bv && !s_axi_bready;
    endsequence
    sequence s_shot;
        run_tk && hit_per && st.som;
    endsequence

    property p_idle_lvl;
        st.fsm == tpo_pkg::TPO_IDLE |=> st.wout == $past(st.lvl);
    endproperty
    a_idle_lvl: assert property (p_idle_lvl) else $error("idle level wrong");
    property p_stop;
        s_shot |=> st.fsm != tpo_pkg::TPO_RUN && st.wout == $past(st.lvl);
    endproperty
    a_stop: assert property (p_stop) else $error("no stop on period");
    property p_clr;
        s_shot |=> st.cnt == ($past(st.clear_select_bit) ? tpo_pkg::CNT_ZERO : $past(st.cnt));
    endproperty
    a_clr: assert property (p_clr) else $error("counter clear wrong");
    property p_wrap;
        run_tk && hit_per && !st.som |=> st.cnt == tpo_pkg::CNT_ZERO && st.fsm == tpo_pkg::TPO_RUN;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");
    property p_act;
        run_tk && hit_wait && !hit_end && !hit_per |=> st.wout == !$past(st.lvl);
    endproperty
    a_act: assert property (p_act) else $error("not active at wait");
    property p_inact;
        run_tk && hit_end |=> st.wout == $past(st.lvl);
    endproperty
    a_inact: assert property (p_inact) else $error("not inactive at end");
    property p_ovf;
        run_tk && st.cnt == tpo_pkg::CNT_MAX && !hit_per |=> st.flg[tpo_pkg::F_OVF] && event_pulse;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    property p_halt;
        ctrl_wr && !st.wd[tpo_pkg::B_RUN] |=> st.fsm == tpo_pkg::TPO_IDLE && st.cnt == $past(st.cnt);
    endproperty
    a_halt: assert property (p_halt) else $error("run clear ignored");
    property p_start;
        start_wr && (st.edg == tpo_pkg::EDG_OFF || !st.som) |=> st.fsm == tpo_pkg::TPO_RUN;
    endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_trig;
        st.fsm == tpo_pkg::TPO_ARM && trg_edge && !do_wr |=> st.fsm == tpo_pkg::TPO_RUN;
    endproperty
    a_trig: assert property (p_trig) else $error("trigger missed");
    property p_bhold;
        s_bwait |=> st.bv;
    endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
endmodule

// [tb/tpo_partner.sv]
// partner model: trigger source and external count clocks of the timer
`timescale 1ns/1ps
module tpo_partner (
    // clock
    input  wire logic aclk,
    // level asked for by the bench
    input  wire logic trg_level,
    // pins toward the timer
    output logic      ext_trigger_pin,
    output logic      ext_count_clock_pin,
    output logic      fast_internal_osc_clk
);
    logic [3:0] ph6;
    logic [2:0] ph8;
    initial begin
        ph6 = 4'h0;
        ph8 = 3'h0;
        ext_trigger_pin = 1'b0;
    end
    // pin follows the bench one cycle late, so rising, falling or either edge can be made
    always @(posedge aclk) begin
        ext_trigger_pin <= trg_level;
        ph6 <= (ph6 == 4'h5) ? 4'h0 : ph6 + 4'h1;
        ph8 <= ph8 + 3'h1;
    end
    // free running sources, periods 6 and 8 cycles, unrelated to the prescaler phase
    assign ext_count_clock_pin   = (ph6 < 4'h3);
    assign fast_internal_osc_clk = ph8[2];
endmodule

// [tb/timer_pwm2_oneshot_tb.sv]
// self-checking bench of the pwm2 one-shot timer
`timescale 1ns/1ps
module timer_pwm2_oneshot_tb;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trg;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d, e;
    logic [3:0]  wstrb;
    logic        awready, wready, bvalid, arready, rvalid, wave, evp, xclk, oclk, tpin;
    logic [1:0]  bresp, rresp, lresp;
    int          bad_count, n_tests, ev_cnt, n;
    int          mul[7] = '{1, 2, 4, 8, 32, 8, 6};

    initial aclk = 1'b0;
    always #2 aclk = ~aclk;
    always @(posedge aclk) if (evp === 1'b1) ev_cnt++;

    tpo_timer uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .ext_count_clock_pin(xclk), .fast_internal_osc_clk(oclk), .ext_trigger_pin(tpin),
        .wave_out_pin(wave), .event_pulse(evp)
    );
    tpo_partner far (
        .aclk(aclk), .trg_level(trg), .ext_trigger_pin(tpin),
        .ext_count_clock_pin(xclk), .fast_internal_osc_clk(oclk)
    );

    // ************
    // shared tasks
    // ************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s: got %h exp %h", $time, m, got, exp);
        end
    endtask
    // address and data offered together, each dropped at its own take
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= v;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        lresp = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        v = rdata;
        lresp = rresp;
        rready <= 1'b0;
    endtask
    // counts cycles until the pin shows v, bounded so a stuck pin cannot hang
    task automatic wt(input logic v, input int lim, output int c);
        c = 0;
        while (wave !== v && c < lim) begin
            @(posedge aclk);
            c++;
        end
    endtask
    // writes the config byte, then the period, end and wait registers
    task automatic cfgw(input logic [7:0] c, input logic [15:0] m, input logic [15:0] nv, input logic [15:0] p);
        wr(8'h04, {24'h0, c});
        wr(8'h08, {16'h0, m});
        wr(8'h0C, {16'h0, nv});
        wr(8'h10, {16'h0, p});
    endtask

    // ************
    // scenarios
    // ************
    task automatic t_reset;
        chk(wave, 1'b0, "idle level");
        rd(8'h04, d);
        chk(d, 32'h0, "cfg reset");
        wr(8'h1C, 32'h1);
        chk(lresp, 2'h2, "unmapped write");
        rd(8'h1C, d);
        chk({lresp, d[29:0]}, 32'h80000000, "unmapped read");
        $display("reset and bus test done");
    endtask
    // every count source: width of the pulse scales with the tick period
    task automatic t_src;
        for (int i = 0; i < 7; i++) begin
            cfgw(8'h82 | 8'(i << 2), 16'h7, 16'h5, 16'h2);
            wr(8'h00, 32'h1);
            wt(1'b1, 900, n);
            wt(1'b0, 900, n);
            chk(32'(n), 32'(3 * mul[i]), "active width");
            repeat (4 * mul[i] + 8) @(posedge aclk);
            rd(8'h00, d);
            chk(d[0], 1'b0, "one-shot halt");
            chk(wave, 1'b0, "back to initial");
            rd(8'h14, d);
            chk(d, 32'h0, "counter cleared");
        end
        $display("source test done");
    endtask
    // wait grows by exactly the change in the wait register
    task automatic t_delay;
        int dl[2];
        for (int k = 0; k < 2; k++) begin
            cfgw(8'h82, 16'h7, 16'h6, 16'(1 + 3 * k));
            wr(8'h00, 32'h1);
            wt(1'b1, 100, dl[k]);
            repeat (12) @(posedge aclk);
        end
        chk(32'(dl[1] - dl[0]), 32'h3, "wait delta");
        $display("delay test done");
    endtask
    // active low, divide by 2, trigger field set but no stop: runs free
    task automatic t_cont;
        cfgw(8'h25, 16'h9, 16'h6, 16'h2);
        wr(8'h00, 32'h1);
        wt(1'b0, 200, n);
        wt(1'b1, 200, n);
        chk(32'(n), 32'h8, "low width");
        wt(1'b0, 200, n);
        chk(32'(n), 32'hC, "rest of period");
        wr(8'h00, 32'h0);
        repeat (4) @(posedge aclk);
        chk(wave, 1'b1, "stop level");
        rd(8'h14, d);
        repeat (10) @(posedge aclk);
        rd(8'h14, e);
        chk(e, d, "count kept");
        $display("continuous test done");
    endtask
    // rising, falling, both: a wrong edge must leave the block armed
    task automatic t_trig;
        for (int k = 1; k < 4; k++) begin
            cfgw(8'h80 | 8'(k << 5), 16'h4, 16'h3, 16'h1);
            wr(8'h14, 32'h0);
            trg <= (k == 1);
            repeat (6) @(posedge aclk);
            wr(8'h00, 32'h1);
            trg <= ~trg;
            if (k != 3) begin
                repeat (20) @(posedge aclk);
                chk(wave, 1'b0, "wrong edge");
                trg <= ~trg;
            end
            wt(1'b1, 60, n);
            chk(32'(n < 60), 32'h1, "trigger start");
            wt(1'b0, 60, n);
            repeat (8) @(posedge aclk);
            rd(8'h14, d);
            chk(d, 32'h4, "count kept at stop");
            rd(8'h00, d);
            chk(d[0], 1'b1, "re-armed");
            wr(8'h00, 32'h0);
        end
        $display("trigger test done");
    endtask
    // overflow plus all three compare matches
    task automatic t_flags;
        cfgw(8'h00, 16'h5, 16'h3, 16'h2);
        wr(8'h14, 32'hFFFE);
        wr(8'h18, 32'hF);
        ev_cnt = 0;
        wr(8'h00, 32'h1);
        repeat (40) @(posedge aclk);
        wr(8'h00, 32'h0);
        rd(8'h18, d);
        chk(d[3:0], 4'hF, "match flags");
        chk(32'(ev_cnt > 4), 32'h1, "events");
        wr(8'h18, 32'hF);
        rd(8'h18, d);
        chk(d[4:0], 5'h0, "flags cleared");
        chk(d[5], trg, "trigger level");
        chk(d[6], 1'b0, "output stopped");
        // code 7 selects no count source: a started counter must stand still
        cfgw(8'h1C, 16'h5, 16'h3, 16'h2);
        wr(8'h14, 32'h0);
        wr(8'h00, 32'h1);
        repeat (20) @(posedge aclk);
        rd(8'h14, d);
        chk(d, 32'h0, "no count source");
        wr(8'h00, 32'h0);
        // only the second byte lane of the period is written
        wstrb <= 4'h2;
        wr(8'h08, 32'h1234);
        wstrb <= 4'hF;
        rd(8'h08, d);
        chk(d, 32'h1205, "byte strobe");
        $display("flag test done");
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ************
    // main sequence and watchdog
    // ************
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, trg} = 7'h0;
        {awaddr, araddr, wdata} = 48'h0;
        wstrb = 4'hF;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset;
        t_src;
        t_delay;
        t_cont;
        t_trig;
        t_flags;
        final_report;
    end
    // whole run needs well under 20000 cycles
    initial begin
        #200000;
        bad_count++;
        $display("[ERR] %0t watchdog expired", $time);
        final_report;
    end
endmodule
